// File: stp_pkg.sv
// constants and types shared by the sram test access port
package stp_pkg;
  // instruction register geometry and codes
  localparam int IR_W = 3;
  localparam logic [2:0] IR_CAPT_HIZ = 3'h0;
  localparam logic [2:0] IR_IDENT = 3'h1;
  localparam logic [2:0] IR_SAMPLE_HIZ = 3'h2;
  localparam logic [2:0] IR_SAMPLE = 3'h4;
  localparam logic [2:0] IR_BYPASS = 3'h7;
  // reset value of the instruction register
  localparam logic [2:0] IR_RESET = IR_IDENT;
  // fixed pattern loaded while capturing the instruction register
  localparam logic [2:0] IR_CAP_PAT = 3'h1;

  // data register lengths
  localparam int ID_W = 32;
  localparam int BYP_W = 1;
  localparam int BSR_LEN_DEF = 71;
  // identification word; value is arbitrary, bit 0 set as presence marker
  localparam logic [31:0] ID_CODE_DEF = 32'h2A5C_3001;

  // consecutive tms-high rising edges that always reach test-logic-reset
  localparam logic [2:0] RESET_ONES = 3'h5;

  // one-hot test access states
  typedef enum logic [15:0] {
    ST_TLR    = 16'h0001,
    ST_RTI    = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR  = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PA_DR  = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR  = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PA_IR  = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } stp_tap_t;
endpackage

// File: stp_fifo.sv
// small fifo with registered storage and valid/ready on both sides
module stp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } stp_fifo_t;

  stp_fifo_t st;
  stp_fifo_t next_st;
  logic push;
  logic pop;

  // honest flags straight from the occupancy count
  assign in_ready = (st.cnt != FULL);
  assign out_valid = (st.cnt != '0);
  assign out_data = st.mem[st.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and count update; push and pop may share a cycle
  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.mem[st.wp] = in_data;
      next_st.wp = (st.wp == LAST) ? '0 : st.wp + 1'b1;
    end
    if (pop)
    begin
      next_st.rp = (st.rp == LAST) ? '0 : st.rp + 1'b1;
    end
    if (push && !pop)
    begin
      next_st.cnt = st.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end
endmodule

// File: stp_tap.sv
// test access port instruction and data register logic for the sram
//
// Contract
// - decode a three-bit instruction register, eight codes, five implemented functions.
// - in Shift-IR the instruction register shifts between tdi and tdo.
// - a shifted instruction takes effect only at Update-IR.
// - no path drives address, data or control into the core; no preload.
// - all-zeros code acts as sample but also forces memory outputs high-z.
// - identification code captures the fixed 32-bit word and shifts it out.
// - identification is the current instruction after power-up and in Test-Logic-Reset.
// - high-z sample selects the boundary register and holds outputs high-z.
// - sample captures every input and bidirectional pin in Capture-DR.
// - after capture, Shift-DR shifts the boundary register out serially.
// - Update-DR under sample changes nothing, just like Pause-DR.
// - bypass places a one-bit register between tdi and tdo.
// - codes 000, 001, 010 are all-zeros capture, identification, high-z sample.
// - 100 is sample, 111 bypass; 011, 101, 110 are reserved.
// - five tms-high rising tck edges reset the port, memory undisturbed.
// - Capture-IR loads 01 into the two low instruction bits.
module stp_tap #(
  parameter int BSR_LEN = stp_pkg::BSR_LEN_DEF,
  parameter logic [31:0] ID_CODE = stp_pkg::ID_CODE_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [BSR_LEN-1:0] pin_snap,
  output logic sram_out_hiz,
  output logic snap_valid,
  output logic [BSR_LEN-1:0] snap_data,
  input wire logic snap_ready
);
  typedef struct packed {
    stp_pkg::stp_tap_t tap;
    logic [2:0] ir;
    logic [2:0] ir_sr;
    logic [BSR_LEN-1:0] sr;
    logic tdo;
    logic tdo_oe;
    logic hiz;
    logic tck_m;
    logic tck_s;
    logic tck_d;
    logic tms_m;
    logic tms_s;
    logic tdi_m;
    logic tdi_s;
    logic [BSR_LEN-1:0] pin_m;
    logic [BSR_LEN-1:0] pin_s;
    logic pend;
    logic [BSR_LEN-1:0] pend_data;
  } stp_state_t;

  stp_state_t st;
  stp_state_t next_st;
  logic rise;
  logic fall;
  logic shifting;
  logic ident;
  logic boundary;
  logic hiz_dec;
  logic fifo_ready;

  // tck edges found from the settled copies only, never the first flop
  assign rise = st.tck_s && !st.tck_d;
  assign fall = !st.tck_s && st.tck_d;
  assign shifting = (st.tap == stp_pkg::ST_SH_DR) || (st.tap == stp_pkg::ST_SH_IR);

  // instruction decode; reserved codes fall through to the bypass bit
  assign ident = (st.ir == stp_pkg::IR_IDENT);
  assign boundary = (st.ir == stp_pkg::IR_CAPT_HIZ) || (st.ir == stp_pkg::IR_SAMPLE_HIZ)
                    || (st.ir == stp_pkg::IR_SAMPLE);
  assign hiz_dec = (st.ir == stp_pkg::IR_CAPT_HIZ) || (st.ir == stp_pkg::IR_SAMPLE_HIZ);

  assign tdo = st.tdo;
  assign tdo_oe = st.tdo_oe;
  // only a high-z request leaves the port; no core or buffer drive path exists
  assign sram_out_hiz = st.hiz;

  // sixteen-state controller step on the sampled tms
  function automatic stp_pkg::stp_tap_t tap_step(input stp_pkg::stp_tap_t s, input logic m);
    case (s)
      stp_pkg::ST_TLR:    tap_step = m ? stp_pkg::ST_TLR : stp_pkg::ST_RTI;
      stp_pkg::ST_RTI:    tap_step = m ? stp_pkg::ST_SEL_DR : stp_pkg::ST_RTI;
      stp_pkg::ST_SEL_DR: tap_step = m ? stp_pkg::ST_SEL_IR : stp_pkg::ST_CAP_DR;
      stp_pkg::ST_CAP_DR: tap_step = m ? stp_pkg::ST_EX1_DR : stp_pkg::ST_SH_DR;
      stp_pkg::ST_SH_DR:  tap_step = m ? stp_pkg::ST_EX1_DR : stp_pkg::ST_SH_DR;
      stp_pkg::ST_EX1_DR: tap_step = m ? stp_pkg::ST_UPD_DR : stp_pkg::ST_PA_DR;
      stp_pkg::ST_PA_DR:  tap_step = m ? stp_pkg::ST_EX2_DR : stp_pkg::ST_PA_DR;
      stp_pkg::ST_EX2_DR: tap_step = m ? stp_pkg::ST_UPD_DR : stp_pkg::ST_SH_DR;
      stp_pkg::ST_UPD_DR: tap_step = m ? stp_pkg::ST_SEL_DR : stp_pkg::ST_RTI;
      stp_pkg::ST_SEL_IR: tap_step = m ? stp_pkg::ST_TLR : stp_pkg::ST_CAP_IR;
      stp_pkg::ST_CAP_IR: tap_step = m ? stp_pkg::ST_EX1_IR : stp_pkg::ST_SH_IR;
      stp_pkg::ST_SH_IR:  tap_step = m ? stp_pkg::ST_EX1_IR : stp_pkg::ST_SH_IR;
      stp_pkg::ST_EX1_IR: tap_step = m ? stp_pkg::ST_UPD_IR : stp_pkg::ST_PA_IR;
      stp_pkg::ST_PA_IR:  tap_step = m ? stp_pkg::ST_EX2_IR : stp_pkg::ST_PA_IR;
      stp_pkg::ST_EX2_IR: tap_step = m ? stp_pkg::ST_UPD_IR : stp_pkg::ST_SH_IR;
      stp_pkg::ST_UPD_IR: tap_step = m ? stp_pkg::ST_SEL_DR : stp_pkg::ST_RTI;
      default:            tap_step = stp_pkg::ST_TLR;
    endcase
  endfunction

  // whole next state: synchronisers, controller, registers, tdo, snapshot hand-off
  always_comb
  begin
    int dr_len;
    dr_len = ident ? stp_pkg::ID_W : (boundary ? BSR_LEN : stp_pkg::BYP_W);
    next_st = st;
    next_st.tck_m = tck;
    next_st.tck_s = st.tck_m;
    next_st.tck_d = st.tck_s;
    next_st.tms_m = tms;
    next_st.tms_s = st.tms_m;
    next_st.tdi_m = tdi;
    next_st.tdi_s = st.tdi_m;
    next_st.pin_m = pin_snap;
    next_st.pin_s = st.pin_m;
    next_st.hiz = hiz_dec;
    // a taken hand-off clears pending; a capture in the same cycle re-arms it
    if (st.pend && fifo_ready)
    begin
      next_st.pend = 1'b0;
    end
    if (rise)
    begin
      next_st.tap = tap_step(st.tap, st.tms_s);
      case (st.tap)
        stp_pkg::ST_CAP_IR:
        begin
          next_st.ir_sr = stp_pkg::IR_CAP_PAT;
        end
        stp_pkg::ST_SH_IR:
        begin
          next_st.ir_sr = {st.tdi_s, st.ir_sr[2:1]};
        end
        stp_pkg::ST_UPD_IR:
        begin
          next_st.ir = st.ir_sr;
        end
        stp_pkg::ST_CAP_DR:
        begin
          next_st.sr = '0; // bypass bit captures low
          if (ident)
          begin
            next_st.sr[stp_pkg::ID_W-1:0] = ID_CODE;
          end
          else if (boundary)
          begin
            // memory clock bit may be caught mid-edge
            next_st.sr = st.pin_s;
            next_st.pend = 1'b1;
            next_st.pend_data = st.pin_s;
          end
        end
        stp_pkg::ST_SH_DR:
        begin
          // tdi enters at the msb of the selected length
          for (int i = 0; i < BSR_LEN; i++)
          begin
            if (i == dr_len - 1)
            begin
              next_st.sr[i] = st.tdi_s;
            end
            else if (i < dr_len - 1)
            begin
              next_st.sr[i] = st.sr[i + 1];
            end
            else
            begin
              next_st.sr[i] = 1'b0;
            end
          end
        end
        // update-dr has no preload, so it behaves like pause
        default:
        begin
        end
      endcase
      // entering reset restores the instruction at once, not a tck later
      if (next_st.tap == stp_pkg::ST_TLR)
      begin
        next_st.ir = stp_pkg::IR_RESET;
      end
    end
    // tdo moves only on the falling tck edge
    if (fall)
    begin
      next_st.tdo_oe = shifting;
      if (st.tap == stp_pkg::ST_SH_IR)
      begin
        next_st.tdo = st.ir_sr[0];
      end
      else if (st.tap == stp_pkg::ST_SH_DR)
      begin
        next_st.tdo = st.sr[0];
      end
    end
  end

  // power-up reset doubles as test-logic-reset
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= '0;
      st.tap <= stp_pkg::ST_TLR;
      st.ir <= stp_pkg::IR_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // snapshot stream; a stalled reader holds one word in pending, which the next capture overwrites
  stp_fifo #(
    .W(BSR_LEN),
    .DEPTH(2)
  ) u_snap_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(st.pend),
    .in_data(st.pend_data),
    .in_ready(fifo_ready),
    .out_valid(snap_valid),
    .out_data(snap_data),
    .out_ready(snap_ready)
  );

  // helper: run of tms-high rising edges, saturating at the reset count
  logic [2:0] ones_cnt;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ones_cnt <= 3'h0;
    end
    else if (rise)
    begin
      ones_cnt <= !st.tms_s ? 3'h0
                  : ((ones_cnt == stp_pkg::RESET_ONES) ? ones_cnt : ones_cnt + 3'h1);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  chk_five_ones_reset: assert property (
    ones_cnt == stp_pkg::RESET_ONES |-> st.tap == stp_pkg::ST_TLR)
    else $error("five tms-high edges did not reach reset state");
  chk_reset_ir_ident: assert property (
    st.tap == stp_pkg::ST_TLR |=> st.ir == stp_pkg::IR_IDENT)
    else $error("instruction not identification in reset state");
  chk_capture_ir_pat: assert property (
    rise && st.tap == stp_pkg::ST_CAP_IR |=> st.ir_sr[1:0] == 2'h1)
    else $error("capture-ir pattern wrong");
  chk_update_ir_apply: assert property (
    rise && st.tap == stp_pkg::ST_UPD_IR |=> st.ir == $past(st.ir_sr))
    else $error("instruction not applied at update-ir");
  chk_ir_holds: assert property (
    !(rise && st.tap == stp_pkg::ST_UPD_IR)
    && !(rise && st.tms_s && st.tap == stp_pkg::ST_SEL_IR) |=> $stable(st.ir))
    else $error("instruction changed outside update-ir");
  chk_hiz_follows_ir: assert property (
    $stable(st.ir) |-> sram_out_hiz
    == (st.ir == stp_pkg::IR_CAPT_HIZ || st.ir == stp_pkg::IR_SAMPLE_HIZ))
    else $error("high-z output disagrees with instruction");
  chk_ident_capture: assert property (
    rise && st.tap == stp_pkg::ST_CAP_DR && ident |=> st.sr[31:0] == ID_CODE)
    else $error("identification word not captured");
  chk_bypass_low: assert property (
    rise && st.tap == stp_pkg::ST_CAP_DR && st.ir == stp_pkg::IR_BYPASS |=> st.sr[0] == 1'b0)
    else $error("bypass bit not captured low");
  chk_sample_capture: assert property (
    rise && st.tap == stp_pkg::ST_CAP_DR && boundary |=> st.sr == $past(st.pin_s) && st.pend)
    else $error("pin snapshot not captured");
  chk_update_dr_quiet: assert property (
    rise && st.tap == stp_pkg::ST_UPD_DR |=> $stable(st.sr) && $stable(sram_out_hiz))
    else $error("update-dr changed state");
  chk_tdo_on_fall: assert property (
    fall |=> tdo_oe == $past(shifting) && (rise == 1'b0))
    else $error("tdo enable not set at falling edge");

  cov_ident_shift: cover property (rise && st.tap == stp_pkg::ST_SH_DR && ident);
  cov_bypass_shift: cover property (
    rise && st.tap == stp_pkg::ST_SH_DR && st.ir == stp_pkg::IR_BYPASS);
  cov_ir_update: cover property (rise && st.tap == stp_pkg::ST_UPD_IR);
  cov_snap_stall: cover property (st.pend && !fifo_ready);
endmodule

// File: stp_ctl_model.sv
// behavioural boundary-scan controller that drives the test link
module stp_ctl_model (
  input wire logic clk,
  input wire logic tdo,
  input wire logic tdo_oe,
  output logic tck,
  output logic tms,
  output logic tdi
);
  timeunit 1ns;
  timeprecision 100ps;

  // tck rests low between frames, tms and tdi float to their pull-ups
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // one 900 ns tck period; tdo is read late in the low phase, after the fall settled
  task automatic step(input logic m, input logic d, output logic q);
    @(posedge clk);
    #1;
    tms = m;
    tdi = d;
    repeat (4) @(posedge clk);
    #1;
    q = tdo;
    tck = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    tck = 1'b0;
    tdi = 1'b1;
  endtask

  // five tms-high rises, then on to idle
  task automatic tap_reset();
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask

  // from idle into a shift state, n bits lsb first, leaving in exit1
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout, output logic oe_ok);
    logic q;
    dout = '0;
    oe_ok = 1'b1;
    step(1'b1, 1'b1, q);
    if (ir)
      step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
      oe_ok = oe_ok & tdo_oe;
    end
  endtask

  // update then idle; a new instruction only counts from here
  task automatic finish();
    logic q;
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
endmodule

// File: stp_tap_tb.sv
// self-checking bench for the sram test access port against a behavioural reference
module stp_tap_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk;
  logic sys_rst;
  logic tck, tms, tdi, tdo, tdo_oe, sram_out_hiz, snap_valid, rdy_rand, oe_ok;
  logic snap_ready = 1'b0;
  logic [70:0] pin_snap, snap_data;
  logic [31:0] lfsr_q;
  logic [127:0] din, dout, expv;
  logic [70:0] snap_q[$];
  logic [2:0] cur_ir;
  logic [2:0] codes[5];
  int err_count;
  int n_tests;

  stp_tap i_dut (.clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .pin_snap(pin_snap), .sram_out_hiz(sram_out_hiz),
    .snap_valid(snap_valid), .snap_data(snap_data), .snap_ready(snap_ready));
  stp_ctl_model i_ctl (.clk(clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms), .tdi(tdi));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic hz(input logic [2:0] c);
    return c == stp_pkg::IR_CAPT_HIZ || c == stp_pkg::IR_SAMPLE_HIZ;
  endfunction

  task automatic check(input logic [127:0] got, input logic [127:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic stop_test();
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ready toggles while enabled, so the stream sees stalls between hand-offs
  always @(posedge clk)
    snap_ready <= #1 rdy_rand & ~snap_ready;

  // reference queue of captured boundary words, popped on each hand-off
  always @(posedge clk)
    if (snap_valid === 1'b1 && snap_ready === 1'b1)
    begin
      if (snap_q.size() == 0)
        check(1, 0, "extra snapshot");
      else
        check(128'(snap_data), 128'(snap_q.pop_front()), "snapshot word");
    end

  task automatic ir_load(input logic [2:0] c);
    i_ctl.scan(1'b1, 3, 128'(c), dout, oe_ok);
    check(dout[1:0], 2'h1, "ir capture");
    check(sram_out_hiz, hz(cur_ir), "hiz before update");
    check(oe_ok, 1, "oe in shift-ir");
    i_ctl.finish();
    cur_ir = c;
    check(sram_out_hiz, hz(c), "hiz after update");
  endtask

  // eight extra bits show the register length as well as its capture
  task automatic dr_check();
    int len;
    logic [127:0] cap;
    lfsr_q = lfsr(lfsr_q);
    pin_snap = {lfsr_q[6:0], lfsr_q, ~lfsr_q}; // still over capture, clock bit exact
    lfsr_q = lfsr(lfsr_q);
    din = {4{lfsr_q}};
    len = (cur_ir == stp_pkg::IR_IDENT) ? 32 : (cur_ir == stp_pkg::IR_BYPASS) ? 1 : 71;
    cap = (len == 32) ? 128'(stp_pkg::ID_CODE_DEF) : (len == 71) ? 128'(pin_snap) : '0;
    if (len == 71)
      snap_q.push_back(pin_snap);
    i_ctl.scan(1'b0, len + 8, din, dout, oe_ok);
    i_ctl.finish();
    expv = (cap | (din << len)) & ((128'h1 << (len + 8)) - 1);
    check(dout, expv, "data scan");
    check(oe_ok, 1, "oe in shift-dr");
    check(tdo_oe, 0, "tdo floats after shift");
    check(sram_out_hiz, hz(cur_ir), "hiz after update-dr");
  endtask

  initial
  begin
    #5_000_000;
    check(0, 1, "run timeout");
    stop_test();
  end

  initial
  begin
    sys_rst = 1'b1;
    pin_snap = '0;
    rdy_rand = 1'b1;
    lfsr_q = 32'h0001_4C50;
    err_count = 0;
    n_tests = 0;
    cur_ir = stp_pkg::IR_RESET;
    // reserved codes never loaded, they carry no function
    codes = '{stp_pkg::IR_CAPT_HIZ, stp_pkg::IR_IDENT, stp_pkg::IR_SAMPLE_HIZ,
              stp_pkg::IR_SAMPLE, stp_pkg::IR_BYPASS};
    repeat (4) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    check(tdo_oe, 0, "tdo floats after reset");
    check(sram_out_hiz, 0, "outputs live after reset");
    i_ctl.tap_reset();
    dr_check();
    // each implemented code, scanned twice so update-dr proves inert
    foreach (codes[k])
    begin
      ir_load(codes[k]);
      repeat (2) dr_check();
    end
    // tms reset out of bypass brings identification back
    i_ctl.tap_reset();
    cur_ir = stp_pkg::IR_RESET;
    dr_check();
    // stalled stream: two words fill the buffer, a third waits
    rdy_rand = 1'b0;
    ir_load(stp_pkg::IR_SAMPLE);
    repeat (3) dr_check();
    check(snap_valid, 1, "stream holds words");
    rdy_rand = 1'b1;
    for (int i = 0; i < 200 && snap_q.size() > 0; i++)
      @(posedge clk);
    repeat (4) @(posedge clk);
    #1;
    check(snap_q.size(), 0, "stream drained");
    check(snap_valid, 0, "stream empty");
    stop_test();
  end
endmodule
